//--- src/sgf_pkg.sv
package sgf_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] FRAME_SIZE_LIMIT_CTRL_OFS = 8'h04;
	localparam logic [7:0] VLAN_SNOOP_PORT5_MODE_CTRL_OFS = 8'h05;
	localparam logic [7:0] PORT5_LINK_FLOW_STORM_CTRL_OFS = 8'h06;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int HUGE_FRAME_BIT = 2;
	localparam int SIZE_CHECK_DIS_BIT = 1;
	localparam int VLAN_EN_BIT = 7;
	localparam int IGMP_SNOOP_BIT = 6;
	localparam int DIRECT_MODE_BIT = 5;
	localparam int PRETAG_BIT = 4;
	localparam int TAG_MASK_BIT = 1;
	localparam int SNIFF_AND_BIT = 0;
	localparam int PORT5_BACKPRESSURE_BIT = 7;

	// writable bits and values after reset
	localparam logic [7:0] FRAME_SIZE_WMASK = 8'hfe;
	localparam logic [7:0] FRAME_SIZE_RESET = 8'hf0;
	localparam logic [7:0] VLAN_MODE_WMASK = 8'hf3;
	localparam logic [7:0] VLAN_MODE_RESET = 8'h00;
	localparam logic [7:0] PORT5_FLOW_RESET = 8'h00;

	// ----------------------------------------
	// frame length limits in bytes
	// ----------------------------------------
	localparam logic [11:0] LEN_HUGE = 12'd1916;
	localparam logic [11:0] LEN_NOCHECK = 12'd1536;
	localparam logic [11:0] LEN_TAGGED = 12'd1522;
	localparam logic [11:0] LEN_UNTAGGED = 12'd1518;

	// cycles after reset release before the synced strap is valid
	// two synchroniser stages are cleared by reset, so the pin shows in stage two at the second edge
	localparam logic [1:0] STRAP_WAIT_RESET = 2'd3;
endpackage : sgf_pkg

//--- src/sgf_len_check.sv
`timescale 1ns/1ps
// ----------------------------------------
// frame length counter and size check
// ----------------------------------------
module sgf_len_check (
	input wire logic ref_clk, // core clock
	input wire logic rst, // sync reset, high
	input wire logic frame_start, // first byte of destination address
	input wire logic byte_valid, // one frame byte this cycle
	input wire logic frame_end, // last fcs byte this cycle
	input wire logic [11:0] max_len, // selected limit in bytes
	output logic drop // one-cycle pulse: frame too long
);
	typedef struct packed {
		logic [11:0] cnt;
		logic drop;
	} sgf_len_s;

	sgf_len_s s_q;
	sgf_len_s s_d;
	logic [11:0] cnt_now;

	// count saturates so very long frames still compare as too long
	always_comb begin
		s_d = s_q;
		cnt_now = frame_start ? 12'd0 : s_q.cnt;
		if (byte_valid && cnt_now != 12'hfff) begin
			cnt_now = cnt_now + 12'd1; // RL15
		end
		s_d.cnt = frame_end ? 12'd0 : cnt_now;
		s_d.drop = frame_end && (cnt_now > max_len); // RL4
	end

	// state register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign drop = s_q.drop;
endmodule : sgf_len_check

//--- src/sgf_ctrl.sv
`timescale 1ns/1ps
// Function
// RL1: huge bit allows 1916 bytes, overrides check
// RL2: check-disable bit alone allows 1536 bytes
// RL3: default 1522 tagged, 1518 untagged; cpu-tag exempt (code limits cpu-tagged frames to 1536)
// RL4: drop frames longer than selected limit
// RL5: check-disable bit loaded from strap
// RL6: vlan enable bit turns on 802.1q
// RL7: igmp snoop sends igmp to port 5
// RL8: direct mode forwards by preamble code
// RL9: pre-tag marks port-5 frames with source
// RL10: tag mask uses vid low 5 bits
// RL11: tag mask only works with vlan off
// RL12: sniff and-mode needs both ports match
// RL13: sniff or-mode needs either port match
// RL14: back-pressure bit enables port-5 back pressure
// RL15: length counts destination address through fcs
// RL16: reserved bits read zero, writes ignored
module sgf_ctrl (
	input wire logic ref_clk, // core clock, 125 MHz
	input wire logic rst, // sync reset, high
	input wire logic size_limit_strap_pin, // strap, pin domain
	input wire logic [7:0] reg_addr, // register port address
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	input wire logic [7:0] reg_wdata, // write data
	output logic [7:0] reg_rdata, // read data, one cycle later
	input wire logic rx_frame_start, // first byte of received frame
	input wire logic rx_byte_valid, // received byte strobe
	input wire logic rx_frame_end, // last byte of received frame
	input wire logic rx_tagged, // frame carries 802.1q tag
	input wire logic rx_cpu_tag, // special_cpu_tag_id toward ports 1-4
	output logic rx_drop, // oversize frame drop pulse
	input wire logic fwd_valid, // forwarding lookup request
	input wire logic fwd_igmp, // frame is igmp
	input wire logic [11:0] fwd_vid, // frame vlan identifier
	input wire logic [4:0] fwd_lookup_mask, // mask from address lookup
	input wire logic [2:0] fwd_src_port, // ingress port number
	input wire logic fwd_sniff_src_match, // source port monitored
	input wire logic fwd_sniff_dst_match, // destination port monitored
	output logic [4:0] fwd_egress_mask, // chosen egress ports
	output logic fwd_sniff_copy, // copy to sniffer port
	output logic [2:0] fwd_pretag_port, // port number for preamble
	output logic fwd_pretag_valid, // pre-tag the port-5 frame
	output logic fwd_done, // decision valid pulse
	input wire logic port5_rx_valid_pin, // port-5 receive valid, pin
	input wire logic [4:0] port5_preamble_code, // port mask from preamble
	output logic [4:0] port5_direct_mask, // captured direct-mode mask
	output logic port5_direct_valid, // direct-mode mask captured pulse
	output logic vlan_enable, // 802.1q mode on
	output logic port5_backpressure_en // half-duplex back pressure
);
	typedef struct packed {
		logic [7:0] size_ctl;
		logic [7:0] mode_ctl;
		logic [7:0] flow_ctl;
		logic [7:0] rdata;
		logic [1:0] strap_wait;
		logic strap_s1;
		logic strap_s2;
		logic rxv_s1;
		logic rxv_s2;
		logic rxv_prev;
		logic [4:0] direct_mask;
		logic direct_valid;
		logic [4:0] egress;
		logic sniff;
		logic [2:0] pretag_port;
		logic pretag_valid;
		logic done;
		logic vlan_en;
		logic bp_en;
	} sgf_ctrl_s;

	sgf_ctrl_s s_q;
	sgf_ctrl_s s_d;
	logic [11:0] max_len;
	logic drop_w;

	// ----------------------------------------
	// frame size selection
	// ----------------------------------------
	always_comb begin
		if (s_q.size_ctl[sgf_pkg::HUGE_FRAME_BIT]) begin
			max_len = sgf_pkg::LEN_HUGE; // RL1
		end else if (s_q.size_ctl[sgf_pkg::SIZE_CHECK_DIS_BIT]) begin
			max_len = sgf_pkg::LEN_NOCHECK; // RL2
		end else if (rx_tagged && !rx_cpu_tag) begin
			max_len = sgf_pkg::LEN_TAGGED; // RL3
		end else if (rx_cpu_tag) begin
			max_len = sgf_pkg::LEN_NOCHECK; // RL3
		end else begin
			max_len = sgf_pkg::LEN_UNTAGGED; // RL3
		end
	end

	sgf_len_check sgf_len_check_i (
		.ref_clk(ref_clk),
		.rst(rst),
		.frame_start(rx_frame_start),
		.byte_valid(rx_byte_valid),
		.frame_end(rx_frame_end),
		.max_len(max_len),
		.drop(drop_w)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		// pin inputs pass two flops before use
		s_d.strap_s1 = size_limit_strap_pin;
		s_d.strap_s2 = s_q.strap_s1;
		s_d.rxv_s1 = port5_rx_valid_pin;
		s_d.rxv_s2 = s_q.rxv_s1;
		s_d.rxv_prev = s_q.rxv_s2;

		// strap caught once the synchroniser has settled; a write wins after that
		if (s_q.strap_wait != 2'd0) begin
			s_d.strap_wait = s_q.strap_wait - 2'd1;
			if (s_q.strap_wait == 2'd1) begin
				s_d.size_ctl[sgf_pkg::SIZE_CHECK_DIS_BIT] = s_q.strap_s2; // RL5
			end
		end

		// register writes, reserved bits masked off
		if (reg_wr) begin
			case (reg_addr)
				sgf_pkg::FRAME_SIZE_LIMIT_CTRL_OFS: s_d.size_ctl = reg_wdata & sgf_pkg::FRAME_SIZE_WMASK; // RL16
				sgf_pkg::VLAN_SNOOP_PORT5_MODE_CTRL_OFS: s_d.mode_ctl = reg_wdata & sgf_pkg::VLAN_MODE_WMASK; // RL16
				sgf_pkg::PORT5_LINK_FLOW_STORM_CTRL_OFS: s_d.flow_ctl = reg_wdata;
				default: s_d.rdata = s_q.rdata;
			endcase
		end

		// read data; unmapped offsets answer zero
		if (reg_rd) begin
			case (reg_addr)
				sgf_pkg::FRAME_SIZE_LIMIT_CTRL_OFS: s_d.rdata = s_q.size_ctl;
				sgf_pkg::VLAN_SNOOP_PORT5_MODE_CTRL_OFS: s_d.rdata = s_q.mode_ctl;
				sgf_pkg::PORT5_LINK_FLOW_STORM_CTRL_OFS: s_d.rdata = s_q.flow_ctl;
				default: s_d.rdata = 8'h00;
			endcase
		end

		// mode levels toward the switch core
		s_d.vlan_en = s_q.mode_ctl[sgf_pkg::VLAN_EN_BIT]; // RL6
		s_d.bp_en = s_q.flow_ctl[sgf_pkg::PORT5_BACKPRESSURE_BIT]; // RL14

		// direct mode: preamble code taken at rising receive valid
		s_d.direct_valid = 1'b0;
		if (s_q.mode_ctl[sgf_pkg::DIRECT_MODE_BIT] && s_q.rxv_s2 && !s_q.rxv_prev) begin
			s_d.direct_mask = port5_preamble_code; // RL8
			s_d.direct_valid = 1'b1; // RL8
		end

		// forwarding decision, one cycle after the request
		s_d.done = fwd_valid;
		if (fwd_valid) begin
			// tag mask is ignored while vlan mode is on
			if (s_q.mode_ctl[sgf_pkg::TAG_MASK_BIT] && !s_q.mode_ctl[sgf_pkg::VLAN_EN_BIT]) begin
				s_d.egress = fwd_vid[4:0]; // RL10 RL11
			end else begin
				s_d.egress = fwd_lookup_mask;
			end
			if (s_q.mode_ctl[sgf_pkg::IGMP_SNOOP_BIT] && fwd_igmp) begin
				s_d.egress[4] = 1'b1; // RL7
			end
			if (s_q.mode_ctl[sgf_pkg::SNIFF_AND_BIT]) begin
				s_d.sniff = fwd_sniff_src_match && fwd_sniff_dst_match; // RL12
			end else begin
				s_d.sniff = fwd_sniff_src_match || fwd_sniff_dst_match; // RL13
			end
			s_d.pretag_port = fwd_src_port;
			s_d.pretag_valid = s_q.mode_ctl[sgf_pkg::PRETAG_BIT] && s_d.egress[4]; // RL9
		end
	end

	// state register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_q <= '0;
			s_q.size_ctl <= sgf_pkg::FRAME_SIZE_RESET;
			s_q.mode_ctl <= sgf_pkg::VLAN_MODE_RESET;
			s_q.flow_ctl <= sgf_pkg::PORT5_FLOW_RESET;
			s_q.strap_wait <= sgf_pkg::STRAP_WAIT_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// drop pulse already comes from a flop in the checker
	assign rx_drop = drop_w;
	assign reg_rdata = s_q.rdata;
	assign fwd_egress_mask = s_q.egress;
	assign fwd_sniff_copy = s_q.sniff;
	assign fwd_pretag_port = s_q.pretag_port;
	assign fwd_pretag_valid = s_q.pretag_valid;
	assign fwd_done = s_q.done;
	assign port5_direct_mask = s_q.direct_mask;
	assign port5_direct_valid = s_q.direct_valid;
	assign vlan_enable = s_q.vlan_en;
	assign port5_backpressure_en = s_q.bp_en;
endmodule : sgf_ctrl

//--- test/sgf_ctrl_sva.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checker
// ----------------------------------------
module sgf_ctrl_sva (
	input wire logic ref_clk, // clock
	input wire logic rst, // reset
	input wire logic [7:0] reg_addr, // addr
	input wire logic reg_wr, // write
	input wire logic reg_rd, // read
	input wire logic [7:0] reg_wdata, // wdata
	input wire logic [7:0] reg_rdata, // rdata
	input wire logic rx_frame_end, // end
	input wire logic rx_drop, // drop
	input wire logic fwd_valid, // req
	input wire logic fwd_igmp, // igmp
	input wire logic [4:0] fwd_lookup_mask, // lookup
	input wire logic fwd_sniff_src_match, // src
	input wire logic fwd_sniff_dst_match, // dst
	input wire logic [4:0] fwd_egress_mask, // egress
	input wire logic fwd_sniff_copy, // sniff
	input wire logic fwd_pretag_valid, // pretag
	input wire logic vlan_enable, // vlan
	input wire logic port5_backpressure_en // bp
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// level outputs trail the register two edges after the write
	a_vlan_follows_write: assert property ((reg_wr && reg_addr == 8'h05) ##1 !(reg_wr && reg_addr == 8'h05)
		|=> vlan_enable == $past(reg_wdata[7], 2)) else $error("vlan enable off");
	a_bp_follows_write: assert property ((reg_wr && reg_addr == 8'h06) ##1 !(reg_wr && reg_addr == 8'h06)
		|=> port5_backpressure_en == $past(reg_wdata[7], 2)) else $error("back pressure off");
	a_reserved_zero: assert property (reg_rd && reg_addr == 8'h05 |=> reg_rdata[3:2] == 2'b00)
		else $error("reserved bits set");
	a_drop_after_end: assert property (rx_drop |-> $past(rx_frame_end) || $past(rx_frame_end, 2))
		else $error("drop without frame end");
	a_sniff_both: assert property (fwd_valid && fwd_sniff_src_match && fwd_sniff_dst_match |=> fwd_sniff_copy)
		else $error("sniff copy missing");
	a_sniff_none: assert property (fwd_valid && !fwd_sniff_src_match && !fwd_sniff_dst_match |=> !fwd_sniff_copy)
		else $error("sniff copy spurious");
	a_lookup_in_vlan: assert property (fwd_valid && vlan_enable && !fwd_igmp ##1 vlan_enable
		|-> fwd_egress_mask == $past(fwd_lookup_mask)) else $error("tag mask used in vlan mode");
	a_pretag_port5: assert property (fwd_pretag_valid |-> fwd_egress_mask[4])
		else $error("pretag without port 5");
endmodule : sgf_ctrl_sva
bind sgf_ctrl sgf_ctrl_sva sgf_ctrl_sva_i (.ref_clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
	.rx_frame_end, .rx_drop, .fwd_valid, .fwd_igmp, .fwd_lookup_mask, .fwd_sniff_src_match, .fwd_sniff_dst_match,
	.fwd_egress_mask, .fwd_sniff_copy, .fwd_pretag_valid, .vlan_enable, .port5_backpressure_en);

//--- test/sgf_mac_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// processor mac on the fifth port
// ----------------------------------------
module sgf_mac_model (
	output logic rx_valid, // receive valid pin
	output logic [4:0] code // preamble code
);
	initial rx_valid = 1'b0;
	initial code = 5'h15;
	// code settles one cycle before valid; called on a falling edge
	task automatic start(input logic [4:0] c);
		code = c;
		#8 rx_valid = 1'b1;
	endtask : start
	// released code is inverted so a stale value is never seen
	task automatic stop();
		rx_valid = 1'b0;
		code = ~code;
	endtask : stop
endmodule : sgf_mac_model

//--- test/tb_switch_global_frame_forward_ctrl.sv
`timescale 1ns/1ps
// ----------------------------------------
// bench
// ----------------------------------------
module tb_switch_global_frame_forward_ctrl;
	logic ref_clk = 1'b0, rst = 1'b1, size_limit_strap_pin = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic rx_frame_start = 1'b0, rx_byte_valid = 1'b0, rx_frame_end = 1'b0, rx_tagged = 1'b0, rx_cpu_tag = 1'b0;
	logic fwd_valid = 1'b0, fwd_igmp = 1'b0, fwd_sniff_src_match = 1'b0, fwd_sniff_dst_match = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic [11:0] fwd_vid = 12'h000;
	logic [4:0] fwd_lookup_mask = 5'h00, fwd_egress_mask, port5_preamble_code, port5_direct_mask;
	logic [2:0] fwd_src_port = 3'h2, fwd_pretag_port;
	logic rx_drop, fwd_sniff_copy, fwd_pretag_valid, fwd_done, port5_rx_valid_pin, port5_direct_valid;
	logic vlan_enable, port5_backpressure_en, seen;
	int failures = 0, n_checks = 0;
	always #4 ref_clk = ~ref_clk;
	sgf_mac_model sgf_mac_model_i (.rx_valid(port5_rx_valid_pin), .code(port5_preamble_code));
	sgf_ctrl sgf_ctrl_i (.ref_clk, .rst, .size_limit_strap_pin, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.rx_frame_start, .rx_byte_valid, .rx_frame_end, .rx_tagged, .rx_cpu_tag, .rx_drop, .fwd_valid, .fwd_igmp,
		.fwd_vid, .fwd_lookup_mask, .fwd_src_port, .fwd_sniff_src_match, .fwd_sniff_dst_match, .fwd_egress_mask,
		.fwd_sniff_copy, .fwd_pretag_port, .fwd_pretag_valid, .fwd_done, .port5_rx_valid_pin, .port5_preamble_code,
		.port5_direct_mask, .port5_direct_valid, .vlan_enable, .port5_backpressure_en);
	task automatic chk(input logic [11:0] s, input logic [11:0] e);
		n_checks++;
		if (s !== e) begin
			failures++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic complete_run();
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : complete_run
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
		@(negedge ref_clk) reg_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge ref_clk) {reg_addr, reg_rd} = {a, 1'b1};
		@(negedge ref_clk) reg_rd = 1'b0;
		chk(12'(reg_rdata), 12'(e));
	endtask : rd
	// whole frame, start to fcs; drop lands one edge after the end, sampled over three falling edges
	task automatic frm(input int n, input logic tg, input logic cpu, input logic e);
		seen = 1'b0;
		for (int i = 0; i < n; i++) begin
			@(negedge ref_clk) {rx_byte_valid, rx_frame_start, rx_frame_end, rx_tagged, rx_cpu_tag} = {1'b1, i == 0, i == n - 1, tg, cpu};
		end
		for (int k = 0; k < 3; k++) begin
			@(negedge ref_clk) {rx_byte_valid, rx_frame_start, rx_frame_end} = 3'b000;
			seen = seen | rx_drop;
		end
		chk(12'(seen), 12'(e));
	endtask : frm
	task automatic fw(input logic ig, input logic [4:0] lk, input logic sm, input logic dm, input logic [4:0] eg, input logic sn);
		@(negedge ref_clk) {fwd_valid, fwd_igmp, fwd_vid, fwd_lookup_mask, fwd_sniff_src_match, fwd_sniff_dst_match} = {1'b1, ig, 12'h00a, lk, sm, dm};
		@(negedge ref_clk) fwd_valid = 1'b0;
		chk(12'({fwd_done, fwd_egress_mask, fwd_sniff_copy}), 12'({1'b1, eg, sn}));
	endtask : fw
	task automatic t_size();
		rd(8'h04, 8'hf2);
		rd(8'h20, 8'h00);
		frm(1536, 1'b0, 1'b0, 1'b0);
		frm(1537, 1'b0, 1'b0, 1'b1);
		wr(8'h04, 8'hf5);
		rd(8'h04, 8'hf4);
		frm(1916, 1'b1, 1'b0, 1'b0);
		frm(1917, 1'b1, 1'b0, 1'b1);
		wr(8'h04, 8'hf0);
		frm(1518, 1'b0, 1'b0, 1'b0);
		frm(1519, 1'b0, 1'b0, 1'b1);
		frm(1522, 1'b1, 1'b0, 1'b0);
		frm(1523, 1'b1, 1'b0, 1'b1);
		frm(1523, 1'b1, 1'b1, 1'b0);
	endtask : t_size
	task automatic t_fwd();
		wr(8'h05, 8'hff);
		rd(8'h05, 8'hf3);
		chk(12'(vlan_enable), 12'h1);
		wr(8'h05, 8'h83);
		fw(1'b0, 5'h05, 1'b1, 1'b0, 5'h05, 1'b0);
		wr(8'h05, 8'h02);
		fw(1'b0, 5'h05, 1'b0, 1'b1, 5'h0a, 1'b1);
		wr(8'h05, 8'h51);
		fw(1'b1, 5'h01, 1'b1, 1'b0, 5'h11, 1'b0);
		chk(12'({fwd_pretag_valid, fwd_pretag_port}), 12'h00a);
		fwd_src_port = 3'h5;
		fw(1'b1, 5'h01, 1'b1, 1'b1, 5'h11, 1'b1);
		chk(12'({fwd_pretag_valid, fwd_pretag_port}), 12'h00d);
	endtask : t_fwd
	// second reset with the strap low: size-check bit must come back clear
	task automatic t_strap();
		wr(8'h05, 8'h80);
		@(negedge ref_clk) {rst, size_limit_strap_pin} = 2'b10;
		repeat (8) @(negedge ref_clk);
		rst = 1'b0;
		repeat (4) @(negedge ref_clk);
		rd(8'h04, 8'hf0);
		chk(12'(vlan_enable), 12'h000);
	endtask : t_strap
	// direct code caught only while the mode bit is set
	task automatic t_link(input logic [7:0] m, input logic e);
		wr(8'h06, m);
		wr(8'h05, m >> 2);
		sgf_mac_model_i.start(5'h0c);
		seen = 1'b0;
		for (int k = 0; k < 12 && !seen; k++) begin
			@(negedge ref_clk) seen = port5_direct_valid;
		end
		sgf_mac_model_i.stop();
		chk(12'({seen, port5_backpressure_en}), 12'({e, e}));
		if (e) chk(12'(port5_direct_mask), 12'h00c);
	endtask : t_link
	initial begin
		repeat (8) @(negedge ref_clk);
		rst = 1'b0;
		repeat (4) @(negedge ref_clk);
		t_size();
		t_fwd();
		t_link(8'h80, 1'b1);
		t_link(8'h00, 1'b0);
		t_strap();
		complete_run();
	end
endmodule : tb_switch_global_frame_forward_ctrl
